// ### rtl/pin_sync.v
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to i_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ns
module pin_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] RESET_VALUE = 3'h4
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [WIDTH-1:0] i_async,
   output reg [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] stage1;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= RESET_VALUE;
         o_sync <= RESET_VALUE;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule // pin_sync

// ### rtl/serial_output_config.v
// Purpose: Serial output configuration registers and output frame shifter
// Assumes: Pins sampled by i_clk; status inputs on i_clk
// Notes: 16-bit command frame {write, 2'b00, addr[4:0], data[7:0]}
// Behaviour
// - General output pin follows bit 12 of output control, reset zero.
// - Bits 9-8 pick second pin: tristate, alarm, general output, data lane.
// - Bit 6 picks sync transmit clock: external serial clock or internal.
// - Clock source bit only matters in source-synchronous output mode.
// - Output mode 0x uses the input clock polarity and phase.
// - Output mode 11b transmits source-synchronously with the selected clock.
// - Reserved output control bits read as zero.
// - Output control bytes sit at 0Ch to 0Fh, low byte first.
// - Content control bytes sit at 10h to 13h with documented fields.
// - Input protocol codes give polarity and phase 00,01,10,11.
// - Parity appends even bits over word, then over frame minus first.
// - Word select: conversion, zeros, ones, alternating bits, alternating pairs.
// - Unit number include inserts four address bits into the stream.
`timescale 1ns/1ns
`include "serial_output_config_defines.vh"
module serial_output_config (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_app_reset,
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_sdi,
   input wire [1:0] i_input_protocol_select,
   input wire [15:0] i_conversion,
   input wire i_alarm,
   input wire [3:0] i_unit_number,
   input wire [1:0] i_supply_alarm_flags,
   input wire [1:0] i_input_alarm_flags,
   input wire [3:0] i_range_setting,
   output reg o_first_output_lane,
   output reg o_first_lane_oe_n,
   output reg o_second_output_lane,
   output reg o_second_lane_oe_n,
   output reg o_general_output_pin,
   output reg o_sync_clock
);
   wire [2:0] synced;
   wire s_cs_n = synced[2];
   wire s_sclk = synced[1];
   wire s_sdi = synced[0];

   pin_sync #(.WIDTH(3), .RESET_VALUE(3'h4)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_cs_n, i_sclk, i_sdi}),
      .o_sync(synced)
   );

   reg [31:0] soc;
   reg [31:0] occ;
   reg d_sclk;
   reg d_cs_n;
   reg f_cpol;
   reg f_cpha;
   reg f_sync;
   reg f_int;
   reg f_two;
   reg [5:0] f_len;
   reg [31:0] sh;
   reg [5:0] cnt;
   reg tog;
   reg run;
   reg [15:0] in_sh;
   reg [4:0] in_cnt;
   reg rd_pending;
   reg [7:0] rd_byte;
   reg [15:0] word;
   reg [31:0] next_frame;
   reg [5:0] next_len;
   reg [31:0] rsel;

   wire rise = s_sclk & ~d_sclk;
   wire fall = ~s_sclk & d_sclk;
   wire cs_fall = ~s_cs_n & d_cs_n;
   wire cs_rise = s_cs_n & ~d_cs_n;
   wire active = ~s_cs_n & ~d_cs_n;
   wire lead = f_cpol ? fall : rise;
   wire trail = f_cpol ? rise : fall;
   wire samp = active & (f_cpha ? trail : lead);
   wire emit = active & (f_sync ? (f_int ? (run & tog) : fall) : (f_cpha ? lead : trail));
   wire [1:0] role = soc[`SOC_ROLE_HI:`SOC_ROLE_LO];
   wire two = (role == `ROLE_DATA);
   wire [5:0] step = two ? 6'h2 : 6'h1;
   wire mode_sync = (soc[`SOC_MODE_HI:`SOC_MODE_LO] == `MODE_SYNC);
   wire [4:0] addr = in_sh[12:8];
   wire hit_soc = ({addr[4:2], 2'b00} == `ADDR_SOC);
   wire hit_occ = ({addr[4:2], 2'b00} == `ADDR_OCC);
   wire [31:0] wmask = 32'h000000ff << {addr[1:0], 3'b000};
   wire [31:0] wword = {24'h000000, in_sh[7:0]} << {addr[1:0], 3'b000};
   wire [31:0] rsh = rsel >> {addr[1:0], 3'b000};
   wire cmd_ok = cs_rise & (in_cnt >= `CMD_LEN);
   wire do_write = cmd_ok & in_sh[15];

   function [31:0] app1;
      input [31:0] f;
      input [5:0] len;
      input b;
      begin
         app1 = f | ({31'h00000000, b} << (6'h1f - len));
      end
   endfunction

   function [31:0] app4;
      input [31:0] f;
      input [5:0] len;
      input [3:0] v;
      begin
         app4 = f | ({28'h0000000, v} << (6'h1c - len));
      end
   endfunction

   always @* begin
      rsel = 32'h00000000;
      if (hit_soc) begin
         rsel = soc;
      end else if (hit_occ) begin
         rsel = occ;
      end
   end

   always @* begin
      if (!occ[`OCC_WORD_HI]) begin
         word = i_conversion;
      end else begin
         case (occ[`OCC_WORD_HI-1:`OCC_WORD_LO])
            2'h0: word = `WORD_ZEROS;
            2'h1: word = `WORD_ONES;
            2'h2: word = `WORD_ALT1;
            default: word = `WORD_ALT2;
         endcase
      end
      if (rd_pending) begin
         word = {8'h00, rd_byte};
      end
      next_frame = {word, 16'h0000};
      next_len = `WORD_LEN;
      if (occ[`OCC_UNIT_BIT]) begin
         next_frame = app4(next_frame, next_len, i_unit_number);
         next_len = next_len + 6'h4;
      end
      if (occ[`OCC_SUPALM_LO]) begin
         next_frame = app1(next_frame, next_len, i_supply_alarm_flags[0]);
         next_len = next_len + 6'h1;
      end
      if (occ[`OCC_SUPALM_HI]) begin
         next_frame = app1(next_frame, next_len, i_supply_alarm_flags[1]);
         next_len = next_len + 6'h1;
      end
      if (occ[`OCC_INALM_LO]) begin
         next_frame = app1(next_frame, next_len, i_input_alarm_flags[0]);
         next_len = next_len + 6'h1;
      end
      if (occ[`OCC_INALM_HI]) begin
         next_frame = app1(next_frame, next_len, i_input_alarm_flags[1]);
         next_len = next_len + 6'h1;
      end
      if (occ[`OCC_RANGE_BIT]) begin
         next_frame = app4(next_frame, next_len, i_range_setting);
         next_len = next_len + 6'h4;
      end
      if (occ[`OCC_PARITY_BIT]) begin
         next_frame = app1(next_frame, next_len + 6'h1, ^next_frame);
         next_frame = app1(next_frame, next_len, ^word);
         next_len = next_len + 6'h2;
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         soc <= `SOC_RESET;
         occ <= `OCC_RESET;
      end else if (i_app_reset) begin
         soc <= `SOC_RESET;
         occ <= `OCC_RESET;
      end else if (do_write & hit_soc) begin
         soc <= (soc & ~(wmask & `SOC_WR_MASK)) | (wword & wmask & `SOC_WR_MASK);
      end else if (do_write & hit_occ) begin
         occ <= (occ & ~(wmask & `OCC_WR_MASK)) | (wword & wmask & `OCC_WR_MASK);
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         d_sclk <= 1'b0;
         d_cs_n <= 1'b1;
         f_cpol <= 1'b0;
         f_cpha <= 1'b0;
         f_sync <= 1'b0;
         f_int <= 1'b0;
         f_two <= 1'b0;
         f_len <= `WORD_LEN;
         sh <= 32'h00000000;
         cnt <= 6'h00;
         tog <= 1'b0;
         run <= 1'b0;
         in_sh <= 16'h0000;
         in_cnt <= 5'h00;
         rd_pending <= 1'b0;
         rd_byte <= 8'h00;
         o_first_output_lane <= 1'b0;
         o_first_lane_oe_n <= 1'b1;
         o_second_output_lane <= 1'b0;
         o_second_lane_oe_n <= 1'b1;
         o_general_output_pin <= 1'b0;
         o_sync_clock <= 1'b0;
      end else begin
         d_sclk <= s_sclk;
         d_cs_n <= s_cs_n;
         o_general_output_pin <= soc[`SOC_LEVEL_BIT];
         o_first_lane_oe_n <= s_cs_n;
         o_second_lane_oe_n <= (role == `ROLE_TRISTATE);
         case (role)
            `ROLE_ALARM: o_second_output_lane <= i_alarm;
            `ROLE_GENERAL: o_second_output_lane <= soc[`SOC_LEVEL_BIT];
            `ROLE_DATA: o_second_output_lane <= o_second_output_lane;
            default: o_second_output_lane <= 1'b0;
         endcase
         if (cs_fall) begin
            f_cpol <= i_input_protocol_select[1];
            f_cpha <= i_input_protocol_select[0];
            f_sync <= mode_sync;
            f_int <= mode_sync & soc[`SOC_CLKSEL_BIT];
            f_two <= two;
            f_len <= next_len;
            in_cnt <= 5'h00;
            rd_pending <= 1'b0;
            run <= mode_sync & soc[`SOC_CLKSEL_BIT];
            tog <= 1'b0;
            if (mode_sync | ~i_input_protocol_select[0]) begin
               o_first_output_lane <= next_frame[31];
               if (two) begin
                  o_second_output_lane <= next_frame[30];
               end
               sh <= two ? {next_frame[29:0], 2'b00} : {next_frame[30:0], 1'b0};
               cnt <= step;
            end else begin
               o_first_output_lane <= 1'b0;
               sh <= next_frame;
               cnt <= 6'h00;
            end
         end else begin
            if (run) begin
               tog <= ~tog;
            end
            if (emit) begin
               if (cnt < f_len) begin
                  o_first_output_lane <= sh[31];
                  if (f_two) begin
                     o_second_output_lane <= sh[30];
                  end
                  sh <= f_two ? {sh[29:0], 2'b00} : {sh[30:0], 1'b0};
                  cnt <= cnt + (f_two ? 6'h2 : 6'h1);
               end else begin
                  o_first_output_lane <= 1'b0;
               end
               if (f_int & (cnt >= f_len)) begin
                  run <= 1'b0;
               end
            end
            if (s_cs_n) begin
               run <= 1'b0;
               tog <= 1'b0;
               o_first_output_lane <= 1'b0;
               if (two) begin
                  o_second_output_lane <= 1'b0;
               end
            end
         end
         if (f_sync & active) begin
            o_sync_clock <= f_int ? (run & ~tog) : s_sclk;
         end else begin
            o_sync_clock <= 1'b0;
         end
         if (samp) begin
            in_sh <= {in_sh[14:0], s_sdi};
            if (in_cnt < `CMD_LEN) begin
               in_cnt <= in_cnt + 5'h01;
            end
         end
         if (cmd_ok & ~in_sh[15]) begin
            rd_pending <= 1'b1;
            rd_byte <= rsh[7:0];
         end
      end
   end
endmodule // serial_output_config

// ### rtl/serial_output_config_defines.vh
// Purpose: Constants for the serial output configuration block
// Assumes: Byte-addressed registers, 5-bit byte address
// Notes: Offsets are byte addresses of each register's lowest byte
`ifndef SERIAL_OUTPUT_CONFIG_DEFINES_VH
`define SERIAL_OUTPUT_CONFIG_DEFINES_VH

`define ADDR_SOC 5'h0c
`define ADDR_OCC 5'h10

`define SOC_RESET 32'h00000000
`define OCC_RESET 32'h00000000
`define SOC_WR_MASK 32'h00001343
`define OCC_WR_MASK 32'h00007d0f

`define SOC_MODE_LO 0
`define SOC_MODE_HI 1
`define SOC_CLKSEL_BIT 6
`define SOC_ROLE_LO 8
`define SOC_ROLE_HI 9
`define SOC_LEVEL_BIT 12

`define OCC_WORD_LO 0
`define OCC_WORD_HI 2
`define OCC_PARITY_BIT 3
`define OCC_RANGE_BIT 8
`define OCC_INALM_LO 10
`define OCC_INALM_HI 11
`define OCC_SUPALM_LO 12
`define OCC_SUPALM_HI 13
`define OCC_UNIT_BIT 14

`define ROLE_TRISTATE 2'h0
`define ROLE_ALARM 2'h1
`define ROLE_GENERAL 2'h2
`define ROLE_DATA 2'h3
`define MODE_SYNC 2'h3

`define WORD_ZEROS 16'h0000
`define WORD_ONES 16'hffff
`define WORD_ALT1 16'h5555
`define WORD_ALT2 16'h3333

`define CMD_LEN 5'h10
`define WORD_LEN 6'h10

`endif

// ### tb/host_spi_model.sv
// Purpose: Host SPI controller model
// Assumes: Input protocol given on i_mode {cpol, cpha}, sclk period 8 i_clk
// Notes: Lane 0 sampled just before each trailing sclk edge
`timescale 1ns/1ns
module host_spi_model (
   input wire i_clk,
   input wire [1:0] i_mode,
   input wire i_lane,
   output reg o_cs_n,
   output reg o_sclk,
   output reg o_sdi
);
   integer i;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdi = 1'b0;
   end
   // Frame of n bits, MSB first; the block acts on the last 16 bits sent
   task xfer(input integer n, input [31:0] tx, output [31:0] rx);
      begin
         rx = 32'h00000000;
         @(posedge i_clk);
         o_cs_n <= 1'b0;
         o_sclk <= i_mode[1];
         repeat (8) @(posedge i_clk);
         for (i = n - 1; i >= 0; i = i - 1) begin
            if (!i_mode[0]) begin
               o_sdi <= tx[i];
            end
            repeat (4) @(posedge i_clk);
            o_sclk <= ~i_mode[1];
            if (i_mode[0]) begin
               o_sdi <= tx[i];
            end
            repeat (4) @(posedge i_clk);
            rx[i] = i_lane;
            o_sclk <= i_mode[1];
         end
         repeat (4) @(posedge i_clk);
         o_cs_n <= 1'b1;
         o_sdi <= ~o_sdi;
         repeat (12) @(posedge i_clk);
      end
   endtask
endmodule // host_spi_model

// ### tb/serial_output_config_assertions.sv
// Purpose: Port checker for the serial output configuration block
// Assumes: One clock domain, async active-low reset
// Notes: Bound to the block below
`timescale 1ns/1ns
module serial_output_config_assertions (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_app_reset,
   input wire i_cs_n,
   input wire o_first_output_lane,
   input wire o_first_lane_oe_n,
   input wire o_second_output_lane,
   input wire o_second_lane_oe_n,
   input wire o_general_output_pin,
   input wire o_sync_clock
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence idle_s;
      i_cs_n[*6];
   endsequence
   sequence busy_s;
      (!i_cs_n && !i_app_reset)[*8];
   endsequence
   lane_idle_a: assert property (idle_s |-> o_first_lane_oe_n && !o_first_output_lane)
      else $error("lane 0 busy when idle");
   lane_busy_a: assert property (!i_cs_n[*5] |-> !o_first_lane_oe_n)
      else $error("lane 0 off in frame");
   sync_idle_a: assert property (idle_s |-> !o_sync_clock)
      else $error("sync clock when idle");
   sync_frame_a: assert property ($rose(o_sync_clock) |-> !o_first_lane_oe_n)
      else $error("sync clock outside frame");
   level_steady_a: assert property (busy_s |=> $stable(o_general_output_pin))
      else $error("level moved in frame");
   role_steady_a: assert property (busy_s |=> $stable(o_second_lane_oe_n))
      else $error("role moved in frame");
   app_clear_a: assert property (i_app_reset |-> ##[1:3] (!o_general_output_pin && o_second_lane_oe_n))
      else $error("app reset not cleared");
   tristate_quiet_a: assert property (o_second_lane_oe_n |-> !o_second_output_lane)
      else $error("lane 1 active off");
endmodule // serial_output_config_assertions
bind serial_output_config serial_output_config_assertions chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_app_reset(i_app_reset), .i_cs_n(i_cs_n), .o_first_output_lane(o_first_output_lane),
   .o_first_lane_oe_n(o_first_lane_oe_n), .o_second_output_lane(o_second_output_lane),
   .o_second_lane_oe_n(o_second_lane_oe_n), .o_general_output_pin(o_general_output_pin),
   .o_sync_clock(o_sync_clock));

// ### tb/testbench.sv
// Purpose: Self-checking bench for the serial output configuration block
// Assumes: Host follows the input protocol held in proto
// Notes: A read returns in the frame after its command
`timescale 1ns/1ns
module testbench;
   reg i_clk = 1'b0;
   reg i_rst_n = 1'b0;
   reg i_app_reset = 1'b0;
   reg i_alarm = 1'b0;
   reg [15:0] conv = 16'h9c3a;
   reg [63:0] wv = 64'hfcfdffffffffffff;
   reg [63:0] rv = 64'h401100000f7d0000;
   reg [127:0] pat = 128'h9c3a9c3a9c3a9c3a0000ffff55553333;
   reg [31:0] rx;
   reg [1:0] proto = 2'h0;
   reg [3:0] unit = 4'h8;
   reg [1:0] sup = 2'h1;
   reg [1:0] inal = 2'h2;
   reg [3:0] rng = 4'h6;
   wire cs_n, sclk, sdi, lane0, lane1, oe0, oe1, general_output_pin, sync_clk;
   // Released lane shows the inverse of its last level
   wire line0 = oe0 ? ~lane0 : lane0;
   integer mismatches = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer rises = 0;
   integer k;
   always #25 i_clk = ~i_clk;
   always @(posedge sync_clk) rises = rises + 1;
   host_spi_model host (.i_clk(i_clk), .i_mode(proto), .i_lane(line0), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_sdi(sdi));
   serial_output_config DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_app_reset(i_app_reset), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_sdi(sdi), .i_input_protocol_select(proto), .i_conversion(conv), .i_alarm(i_alarm),
      .i_unit_number(unit), .i_supply_alarm_flags(sup), .i_input_alarm_flags(inal), .i_range_setting(rng),
      .o_first_output_lane(lane0), .o_first_lane_oe_n(oe0), .o_second_output_lane(lane1),
      .o_second_lane_oe_n(oe1), .o_general_output_pin(general_output_pin), .o_sync_clock(sync_clk));
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [4:0] a, input [7:0] d);
      host.xfer(16, {16'h0000, 3'h4, a, d}, rx);
   endtask
   task rd(input [4:0] a, input [7:0] e);
      begin
         host.xfer(16, {16'h0000, 3'h0, a, 8'h00}, rx);
         host.xfer(16, {16'h0000, 3'h0, a, 8'h00}, rx);
         chk(rx[15:0], {8'h00, e});
      end
   endtask
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         final_report;
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (k = 0; k < 8; k = k + 1)
         rd(k[4:0] + 5'h0c, 8'h00);
      $display("test reset_values done");
      for (k = 0; k < 8; k = k + 1) begin
         wr(k[4:0] + 5'h0c, wv[63 - 8 * k -: 8]);
         rd(k[4:0] + 5'h0c, rv[63 - 8 * k -: 8]);
      end
      chk({15'h0, general_output_pin}, 16'h1);
      $display("test write_masks done");
      for (k = 0; k < 4; k = k + 1) begin
         i_alarm <= (k == 1);
         wr(5'h0d, k == 2 ? 8'h12 : k[7:0]);
         chk({14'h0, oe1, lane1}, (16'h0112 >> (4 * k)) & 16'h0003);
      end
      wr(5'h0d, 8'h00);
      $display("test lane_roles done");
      for (k = 0; k < 8; k = k + 1) begin
         wr(5'h10, k[7:0]);
         wr(5'h1f, 8'h00);
         chk(rx[15:0], pat[127 - 16 * k -: 16]);
      end
      $display("test word_select done");
      for (k = 0; k < 4; k = k + 1) begin
         proto <= k[1:0];
         wr(5'h10, 8'h01 << k);
         rd(5'h10, 8'h01 << k);
      end
      proto <= 2'h0;
      $display("test input_protocols done");
      wr(5'h11, 8'h7d);
      wr(5'h10, 8'h08);
      host.xfer(32, {16'h0000, 3'h4, 5'h1f, 8'h00}, rx);
      chk(rx[31:16], 16'h9c3a);
      chk(rx[15:0], 16'h8964);
      wr(5'h11, 8'h00);
      wr(5'h10, 8'h00);
      $display("test frame_fields done");
      for (k = 0; k < 2; k = k + 1) begin
         wr(5'h0c, k == 0 ? 8'h43 : 8'h03);
         rises = 0;
         wr(5'h0c, 8'h40);
         chk(rises[15:0], 16'h10);
      end
      rises = 0;
      wr(5'h0c, 8'h00);
      chk(rises[15:0], 16'h0);
      $display("test sync_modes done");
      wr(5'h0d, 8'h13);
      i_app_reset <= 1'b1;
      @(posedge i_clk) i_app_reset <= 1'b0;
      rd(5'h0d, 8'h00);
      chk({14'h0, general_output_pin, oe1}, 16'h1);
      chk({15'h0, oe0}, 16'h1);
      $display("test app_reset done");
      final_report;
   end
endmodule // testbench
